/* core/irq_seq_pkg.sv */
// Shared constants for the interrupt sequencer
package irq_seq_pkg;

  localparam int PC_W = 10;
  localparam int PROG_WORDS = 1024;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 10'h3FF;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  localparam logic IE_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  localparam int STACK_DEPTH = 31;
  localparam int SP_W = 5;
  localparam logic [SP_W-1:0] SP_RESET = 5'h00;
  localparam logic [SP_W-1:0] SP_LAST = 5'h1E;
  localparam logic [SP_W-1:0] SP_STEP = 5'h01;

  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_TIME_NS = 40;
  localparam int INSTR_CYCLES = INSTR_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b01,
    PH_EXEC = 2'b10
  } phase_t;

endpackage

/* core/flag_hold.sv */
// Loadable holding register for saved flags
`timescale 1ns/10ps
module flag_hold
  import irq_seq_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (load) begin
      q <= d;
    end
  end

endmodule

/* core/ret_stack.sv */
// Cyclic call/return stack with registered top-of-stack read
`timescale 1ns/10ps
module ret_stack
  import irq_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] push_data,
  output logic [PC_W-1:0] top_q,
  output logic [SP_W-1:0] sp_q
);

  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [SP_W-1:0] top_idx;

  // Wraps at the last slot, so push 32 lands on the oldest entry
  function automatic logic [SP_W-1:0] sp_inc(input logic [SP_W-1:0] p);
    return (p == SP_LAST) ? SP_RESET : p + SP_STEP;
  endfunction

  function automatic logic [SP_W-1:0] sp_dec(input logic [SP_W-1:0] p);
    return (p == SP_RESET) ? SP_LAST : p - SP_STEP;
  endfunction

  assign top_idx = sp_dec(sp_q);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sp_q <= SP_RESET;
    end else if (push) begin
      sp_q <= sp_inc(sp_q);
    end else if (pop) begin
      sp_q <= sp_dec(sp_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[sp_q] <= push_data;
    end
  end

  // Memory has no reset; the top read settles one cycle after a change
  always_ff @(posedge mclk) begin
    top_q <= mem[top_idx];
  end

endmodule

/* core/cpu_interrupt_sequencer.sv */
// Interrupt acceptance, program counter and return sequencing
//
// Overview of operation
// - Interrupt enable is clear after reset; nothing taken until enabled.
// - Enable instruction sets interrupt enable; disable instruction clears.
// - Accepting an interrupt clears interrupt enable automatically.
// - Return from interrupt sets or clears enable as its option bit says.
// - Entry pushes program counter and saves carry and zero flags.
// - Entry loads program counter with last location, 3FF.
// - Instruction fetched at entry is abandoned; its address is saved.
// - Saved flags are those of the last fully completed instruction.
// - Return restores flags and resumes at the saved address.
// - Every slot, entry included, is two cycles; request sampled once.
// - Ten-bit program counter spans 1024 words; vector at the top.
// - Return stack is cyclic with 31 entries; push 32 overwrites oldest.
`timescale 1ns/10ps
module cpu_interrupt_sequencer
  import irq_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic irq_req,
  input wire logic op_int_enable,
  input wire logic op_int_disable,
  input wire logic op_return_from_interrupt,
  input wire logic reti_enable_sel,
  input wire logic op_call,
  input wire logic op_return,
  input wire logic op_jump,
  input wire logic branch_cond_ok,
  input wire logic [PC_W-1:0] branch_target,
  input wire logic flag_write,
  input wire logic carry_next,
  input wire logic zero_next,
  output logic [PC_W-1:0] prog_addr,
  output logic exec_cycle,
  output logic instr_commit,
  output logic int_entry,
  output logic int_enable,
  output logic carry_flag,
  output logic zero_flag
);

  phase_t phase_q;
  logic take_q;
  logic ie_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic carry_q;
  logic zero_q;
  logic [1:0] saved_flags;
  logic [PC_W-1:0] stack_top;
  logic [SP_W-1:0] stack_sp;
  logic is_exec;
  logic commit;
  logic entry;
  logic do_reti;
  logic do_call;
  logic do_ret;
  logic do_jump;

  assign is_exec = (phase_q == PH_EXEC);
  assign entry = is_exec && take_q;
  // Abandoned slot: decoded instruction has no effect
  assign commit = is_exec && !take_q;
  assign do_reti = commit && op_return_from_interrupt;
  assign do_call = commit && op_call && branch_cond_ok;
  assign do_ret = commit && op_return && branch_cond_ok;
  assign do_jump = commit && op_jump && branch_cond_ok;

  assign prog_addr = pc_q;
  assign exec_cycle = is_exec;
  assign instr_commit = commit;
  assign int_entry = entry;
  assign int_enable = ie_q;
  assign carry_flag = carry_q;
  assign zero_flag = zero_q;

  // Fixed two-cycle slot, never stretched
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_q <= PH_FETCH;
    end else begin
      case (phase_q)
        PH_FETCH: phase_q <= PH_EXEC;
        PH_EXEC: phase_q <= PH_FETCH;
        default: phase_q <= PH_FETCH;
      endcase
    end
  end

  // Request seen only on the fetch-cycle edge; a one-cycle pulse
  // elsewhere is missed, which is why the source must hold it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      take_q <= 1'b0;
    end else if (phase_q == PH_FETCH) begin
      take_q <= irq_req && ie_q;
    end else begin
      take_q <= 1'b0;
    end
  end

  // Enable cleared at the entry edge, so next sample sees it low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ie_q <= IE_RESET;
    end else if (entry) begin
      ie_q <= 1'b0;
    end else if (do_reti) begin
      ie_q <= reti_enable_sel;
    end else if (commit && op_int_enable) begin
      ie_q <= 1'b1;
    end else if (commit && op_int_disable) begin
      ie_q <= 1'b0;
    end
  end

  always_comb begin
    pc_d = pc_q;
    if (entry) begin
      pc_d = VECTOR_ADDR;
    end else if (do_reti) begin
      pc_d = stack_top;
    end else if (do_ret) begin
      pc_d = stack_top + PC_STEP;
    end else if (do_call || do_jump) begin
      pc_d = branch_target;
    end else if (commit) begin
      pc_d = pc_q + PC_STEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pc_q <= PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Flags only change when an instruction really completes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      carry_q <= FLAG_RESET;
      zero_q <= FLAG_RESET;
    end else if (do_reti) begin
      carry_q <= saved_flags[1];
      zero_q <= saved_flags[0];
    end else if (commit && flag_write) begin
      carry_q <= carry_next;
      zero_q <= zero_next;
    end
  end

  // Current flags at entry belong to the last completed instruction
  flag_hold #(
    .W(2)
  ) u_flag_save (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(entry),
    .d({carry_q, zero_q}),
    .q(saved_flags)
  );

  // Entry pushes the abandoned address, so the return reruns it
  ret_stack u_stack (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .push(entry || do_call),
    .pop(do_reti || do_ret),
    .push_data(pc_q),
    .top_q(stack_top),
    .sp_q(stack_sp)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_reset_ie;
    @(posedge mclk) disable iff (1'b0) sys_rst |=> !int_enable;
  endproperty
  reset_ie_off_a: assert property (p_reset_ie)
    else $error("interrupt enable not clear after reset");

  ie_set_a: assert property (
    commit && op_int_enable && !op_return_from_interrupt
    |=> int_enable)
    else $error("enable instruction did not set enable");

  ie_clear_a: assert property (
    commit && op_int_disable && !op_return_from_interrupt
    && !op_int_enable |=> !int_enable)
    else $error("disable instruction did not clear enable");

  entry_vector_a: assert property (
    int_entry |=> !int_enable && prog_addr == VECTOR_ADDR)
    else $error("entry did not clear enable or force vector");

  reti_option_a: assert property (
    do_reti |=> int_enable == $past(reti_enable_sel))
    else $error("return did not apply enable option");

  entry_push_a: assert property (
    int_entry |-> ##2 stack_top == $past(prog_addr, 2))
    else $error("abandoned address not on stack");

  flags_saved_a: assert property (
    int_entry |=> saved_flags == $past({carry_flag, zero_flag}))
    else $error("saved flags differ from completed flags");

  abandon_flags_a: assert property (
    int_entry |=> carry_flag == $past(carry_flag)
    && zero_flag == $past(zero_flag))
    else $error("abandoned instruction changed flags");

  reti_restore_a: assert property (
    do_reti |=> prog_addr == $past(stack_top)
    && {carry_flag, zero_flag} == $past(saved_flags))
    else $error("return did not restore address and flags");

  slot_len_a: assert property (
    !exec_cycle |=> exec_cycle ##1 !exec_cycle)
    else $error("instruction slot not two cycles");

  accept_gate_a: assert property (
    !exec_cycle && !(irq_req && int_enable) |=> !int_entry)
    else $error("interrupt taken without request and enable");

  no_reentry_a: assert property (
    int_entry |-> ##2 !int_entry)
    else $error("interrupt accepted during entry slot");

  stack_wrap_a: assert property (
    int_entry && stack_sp == SP_LAST |=> stack_sp == SP_RESET)
    else $error("stack pointer did not wrap at 31 entries");

  // Reset check must not be switched off by the reset it watches
  reset_state_a: assert property (
    @(posedge mclk) disable iff (1'b0)
    sys_rst |=> prog_addr == PC_RESET && !exec_cycle && !int_entry
    && !carry_flag && !zero_flag)
    else $error("state after reset not at its defaults");

  entry_cause_a: assert property (
    int_entry |-> $past(irq_req) && $past(int_enable))
    else $error("entry without sampled request and enable");

  entry_exec_a: assert property (
    int_entry |-> exec_cycle)
    else $error("entry outside the second cycle of a slot");

  addr_stable_a: assert property (
    exec_cycle |-> $stable(prog_addr))
    else $error("program address changed inside a slot");

  seq_step_a: assert property (
    instr_commit && !op_call && !op_jump && !op_return
    && !op_return_from_interrupt
    |=> prog_addr == $past(prog_addr) + PC_STEP)
    else $error("sequential address step wrong");

  vector_fetch_a: assert property (
    int_entry |=> !exec_cycle ##1 (exec_cycle && prog_addr == VECTOR_ADDR))
    else $error("vector instruction not executed after entry");

  abandon_ie_a: assert property (
    int_entry && op_int_enable |=> !int_enable)
    else $error("abandoned enable instruction took effect");

  entry_sp_a: assert property (
    int_entry && stack_sp != SP_LAST
    |=> stack_sp == $past(stack_sp) + SP_STEP)
    else $error("entry did not advance stack pointer");

  call_wrap_a: assert property (
    do_call && stack_sp == SP_LAST |=> stack_sp == SP_RESET)
    else $error("call did not wrap stack pointer");

  ie_hold_a: assert property (
    !int_enable && !instr_commit |=> !int_enable)
    else $error("enable set outside an executed instruction");

  flags_hold_a: assert property (
    !instr_commit |=> $stable({carry_flag, zero_flag}))
    else $error("flags changed outside an executed instruction");

  reti_runs_a: assert property (
    do_reti && !reti_enable_sel |=> ##1 instr_commit)
    else $error("resumed instruction was not executed");

  entry_seen_c: cover property (int_entry ##[2:40] do_reti);
  reti_enable_c: cover property (do_reti && reti_enable_sel);
  stack_wrap_c: cover property (do_call && stack_sp == SP_LAST);
  nested_entry_c: cover property (int_entry ##[2:400] int_entry);
  abandon_flag_c: cover property (int_entry && flag_write);

endmodule

/* dv/irq_source.sv */
// Outside logic that raises the interrupt and takes the vector acknowledge
`timescale 1ns/10ps
module irq_source
  import irq_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fire,
  input wire logic [PC_W-1:0] prog_addr,
  output logic irq_req
);
  // Level held until the vector shows; raised on the entry edge, it lasts only the one vector-fetch cycle
  always_ff @(posedge mclk) begin
    if (sys_rst || prog_addr == VECTOR_ADDR) begin
      irq_req <= 1'b0;
    end else if (fire) begin
      irq_req <= 1'b1;
    end
  end
endmodule

/* dv/cpu_interrupt_sequencer_bench.sv */
// Self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
module cpu_interrupt_sequencer_bench;
  import irq_seq_pkg::*;
  localparam int NOP = 0, EN = 1, DIS = 2, RTI = 3, JMP = 4;
  localparam int JNT = 5, CAL = 6, RET = 7, FLG = 8;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic fire = 1'b0;
  logic op_int_enable = 1'b0, op_int_disable = 1'b0, reti_enable_sel = 1'b0;
  logic op_return_from_interrupt = 1'b0, op_call = 1'b0, op_return = 1'b0;
  logic op_jump = 1'b0, branch_cond_ok = 1'b0, flag_write = 1'b0;
  logic carry_next = 1'b0, zero_next = 1'b0;
  logic [PC_W-1:0] branch_target = 10'h000;
  logic [PC_W-1:0] prog_addr;
  logic irq_req, exec_cycle, instr_commit, int_entry, int_enable;
  logic carry_flag, zero_flag;
  logic [PC_W-1:0] pc_m = PC_RESET;
  logic ie_m = 1'b0, c_m = 1'b0, z_m = 1'b0, sc_m = 1'b0, sz_m = 1'b0;
  logic pend_m = 1'b0, ent_m = 1'b0, xent = 1'bx;
  logic [PC_W-1:0] stk[$];
  logic [PC_W+3:0] expq[$];
  logic [PC_W+3:0] e;
  int failures = 0, n_checks = 0, op;

  cpu_interrupt_sequencer dut (.mclk, .sys_rst, .irq_req, .op_int_enable,
    .op_int_disable, .op_return_from_interrupt, .reti_enable_sel, .op_call,
    .op_return, .op_jump, .branch_cond_ok, .branch_target, .flag_write,
    .carry_next, .zero_next, .prog_addr, .exec_cycle, .instr_commit,
    .int_entry, .int_enable, .carry_flag, .zero_flag);
  irq_source far_end (.mclk, .sys_rst, .fire, .prog_addr, .irq_req);

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  task automatic complete_run;
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [PC_W+2:0] got, input logic [PC_W+2:0] x);
    n_checks++;
    if (got !== x) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, x);
    end
  endtask

  task automatic drive(input int o, input logic [PC_W-1:0] a, input logic f);
    op_int_enable <= (o == EN);
    op_int_disable <= (o == DIS);
    op_return_from_interrupt <= (o == RTI);
    reti_enable_sel <= a[0];
    op_jump <= (o == JMP || o == JNT);
    op_call <= (o == CAL);
    op_return <= (o == RET);
    branch_cond_ok <= (o != JNT);
    branch_target <= a;
    flag_write <= (o == FLG);
    carry_next <= a[1];
    zero_next <= a[0];
    fire <= f;
  endtask

  // One two-cycle slot; the model predicts the state seen at the next fetch
  task automatic slot(input int o, input logic [PC_W-1:0] a, input logic f);
    int n;
    logic [PC_W-1:0] nxt;
    n = 0;
    @(negedge mclk);
    while (exec_cycle !== 1'b0 && n < 8) begin
      n++;
      @(negedge mclk);
    end
    check(13'(n), 13'h0000);
    @(posedge mclk);
    drive(o, a, f);
    // Vector fetch acknowledges, so a request there is lost
    if (ent_m || pc_m == VECTOR_ADDR) pend_m = 1'b0;
    else pend_m = pend_m | f;
    nxt = pc_m + PC_STEP;
    if (ent_m) begin
      stk.push_back(pc_m);
      sc_m = c_m;
      sz_m = z_m;
      ie_m = 1'b0;
      nxt = VECTOR_ADDR;
    end else begin
      case (o)
        EN: ie_m = 1'b1;
        DIS: ie_m = 1'b0;
        RTI: begin
          nxt = stk.pop_back();
          c_m = sc_m;
          z_m = sz_m;
          ie_m = a[0];
        end
        JMP: nxt = a;
        CAL: begin
          stk.push_back(pc_m);
          nxt = a;
        end
        RET: nxt = stk.pop_back() + PC_STEP;
        FLG: {c_m, z_m} = a[1:0];
        default: ;
      endcase
    end
    pc_m = nxt;
    if (stk.size() > STACK_DEPTH) void'(stk.pop_front());
    ent_m = pend_m && ie_m;
    expq.push_back({ent_m, pc_m, ie_m, c_m, z_m});
    @(posedge mclk);
    drive(NOP, 10'h000, 1'b0);
  endtask

  always @(negedge mclk) begin
    if (!sys_rst && exec_cycle === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      check({prog_addr, int_enable, carry_flag, zero_flag},
        e[PC_W+2:0]);
      xent = e[PC_W+3];
    end else if (!sys_rst && exec_cycle === 1'b1 && xent !== 1'bx) begin
      check({11'h000, int_entry, instr_commit},
        {11'h000, xent, !xent});
      xent = 1'bx;
    end
  end

  initial begin
    #(CLK_PERIOD_NS * 4000);
    failures++;
    complete_run();
  end

  initial begin
    void'($urandom(78892));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    expq.push_back({1'b0, PC_RESET, IE_RESET,
      FLAG_RESET, FLAG_RESET});
    slot(FLG, 10'h002, 1'b0);
    slot(NOP, 10'h000, 1'b1);
    slot(NOP, 10'h000, 1'b0);
    slot(EN, 10'h000, 1'b0);
    slot(FLG, 10'h001, 1'b0);
    slot(JMP, 10'h2B0, 1'b0);
    slot(FLG, 10'h001, 1'b0);
    slot(RTI, 10'h001, 1'b0);
    slot(NOP, 10'h000, 1'b1);
    slot(EN, 10'h000, 1'b0);
    slot(JMP, 10'h100, 1'b0);
    slot(RTI, 10'h000, 1'b0);
    slot(JNT, 10'h200, 1'b0);
    for (int i = 0; i < 60; i++) begin
      op = $urandom_range(0, 8);
      if (op == RTI || op == RET) op = FLG;
      slot(op, 10'($urandom_range(0, 10'h3FE)), 1'($urandom_range(0, 1)));
    end
    slot(DIS, 10'h000, 1'b0);
    slot(DIS, 10'h000, 1'b0);
    for (int i = 0; i < 32; i++) slot(CAL, 10'(i * 8 + 8), 1'b0);
    slot(NOP, 10'h000, 1'b0);
    for (int i = 0; i < 31; i++) slot(RET, 10'h000, 1'b0);
    repeat (4) @(posedge mclk);
    check(13'(expq.size()), 13'h0000);
    complete_run();
  end
endmodule
